// file: hdl/port_flow_control_select.sv
// Purpose: port two manual flow control register and its effective outputs
// Assumes: straps and negotiation results arrive from other clock domains
// Notes: register port gives read data one cycle after the read strobe
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "flow_ctrl_defs.svh"
module port_flow_control_select (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`FC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire flow_ctrl_pkg::strap_s strap_pins,
   input wire logic strap_reload,
   input wire flow_ctrl_pkg::strap_s strap_reload_values,
   input wire logic an_enable,
   input wire logic an_pause_rx,
   input wire logic an_pause_tx,
   input wire logic an_half_duplex,
   output logic pause_rx_enable,
   output logic pause_tx_enable,
   output logic backpressure_enable,
   output logic half_duplex_active
);
   // ----------------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------------
   localparam int SYNC_W = 7;
   flow_ctrl_pkg::strap_s strap_sync;
   flow_ctrl_pkg::ctrl_s ctrl_q;
   flow_ctrl_pkg::ctrl_s strap_ctrl;
   flow_ctrl_pkg::ctrl_s reload_ctrl;
   flow_ctrl_pkg::effective_s eff;
   flow_ctrl_pkg::load_state_e state_q;
   logic an_enable_s;
   logic an_pause_rx_s;
   logic an_pause_tx_s;
   logic an_half_s;
   logic [SYNC_W-1:0] sync_in;
   logic [SYNC_W-1:0] sync_out;
   logic hit;
   logic wr_hit;
   logic fill_q;
   logic [`FC_FIELD_W-1:0] status_word;

   // ----------------------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------------------
   // straps and negotiation results come from pins or other clock domains
   assign sync_in = {strap_pins, an_enable, an_pause_rx, an_pause_tx,
                     an_half_duplex};

   sync2 #(
      .W(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d(sync_in),
      .q(sync_out)
   );

   assign strap_sync = sync_out[6:4];
   assign an_enable_s = sync_out[3];
   assign an_pause_rx_s = sync_out[2];
   assign an_pause_tx_s = sync_out[1];
   assign an_half_s = sync_out[0];

   // ----------------------------------------------------------------------------
   // strap mapping onto control fields
   // ----------------------------------------------------------------------------
   // one full duplex strap seeds both manual pause enables
   assign strap_ctrl.backpressure_enable_bit =
      strap_sync.backpressure_default_strap;
   assign strap_ctrl.manual_pause_receive_enable =
      strap_sync.full_duplex_pause_default_strap;
   assign strap_ctrl.manual_pause_transmit_enable =
      strap_sync.full_duplex_pause_default_strap;
   assign strap_ctrl.manual_flow_select =
      strap_sync.manual_select_default_strap;

   // loader values come from logic on this clock, no synchroniser needed
   assign reload_ctrl.backpressure_enable_bit =
      strap_reload_values.backpressure_default_strap;
   assign reload_ctrl.manual_pause_receive_enable =
      strap_reload_values.full_duplex_pause_default_strap;
   assign reload_ctrl.manual_pause_transmit_enable =
      strap_reload_values.full_duplex_pause_default_strap;
   assign reload_ctrl.manual_flow_select =
      strap_reload_values.manual_select_default_strap;

   // ----------------------------------------------------------------------------
   // strap capture sequencing
   // ----------------------------------------------------------------------------
   // the synchroniser needs two edges after release before its output holds
   // the straps, so the reset state waits one extra edge on this flag
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         fill_q <= 1'b0;
      end else begin
         fill_q <= 1'b1;
      end
   end

   // a flop under async reset may only take a constant, so the straps are
   // caught by a clocked load once the synchroniser has filled after release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= flow_ctrl_pkg::ST_RESET;
      end else begin
         case (state_q)
            flow_ctrl_pkg::ST_RESET: begin
               if (fill_q) begin
                  state_q <= flow_ctrl_pkg::ST_LOAD;
               end
            end
            flow_ctrl_pkg::ST_LOAD: begin
               state_q <= flow_ctrl_pkg::ST_RUN;
            end
            flow_ctrl_pkg::ST_RUN: begin
               state_q <= flow_ctrl_pkg::ST_RUN;
            end
            default: begin
               state_q <= flow_ctrl_pkg::ST_RESET;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------------------
   assign hit = (reg_addr == `FC_PORT2_OFFSET);
   assign wr_hit = reg_wr & hit & (state_q == flow_ctrl_pkg::ST_RUN);

   // ----------------------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------------------
   // loader reload wins over a software write in the same cycle, since the
   // loader runs once after reset and software expects its result to hold
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_q <= `FC_CTRL_RESET;
      end else if (state_q == flow_ctrl_pkg::ST_LOAD) begin
         ctrl_q <= strap_ctrl;
      end else if (strap_reload) begin
         ctrl_q <= reload_ctrl;
      end else if (wr_hit) begin
         // only writable bits are taken; status and reserved bits dropped
         ctrl_q.backpressure_enable_bit <=
            reg_wdata[`FC_BIT_BP_EN];
         ctrl_q.manual_pause_receive_enable <= reg_wdata[`FC_BIT_RX_EN];
         ctrl_q.manual_pause_transmit_enable <= reg_wdata[`FC_BIT_TX_EN];
         ctrl_q.manual_flow_select <= reg_wdata[`FC_BIT_MANUAL];
      end
   end

   // ----------------------------------------------------------------------------
   // effective flow control
   // ----------------------------------------------------------------------------
   // advertisement register is not reachable from here, so writes cannot
   // alter what the phy advertises
   flow_resolve u_resolve (
      .ctrl(ctrl_q),
      .an_enable(an_enable_s),
      .an_pause_rx(an_pause_rx_s),
      .an_pause_tx(an_pause_tx_s),
      .half_duplex(an_half_s),
      .eff(eff)
   );

   // outputs registered so the mac sees glitch free levels
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pause_rx_enable <= 1'b0;
         pause_tx_enable <= 1'b0;
         backpressure_enable <= 1'b0;
         half_duplex_active <= 1'b0;
      end else begin
         pause_rx_enable <= eff.pause_rx;
         pause_tx_enable <= eff.pause_tx;
         backpressure_enable <= eff.backpressure;
         half_duplex_active <= eff.half_duplex;
      end
   end

   // ----------------------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------------------
   // status bits read the registered in-force values, matching the mac
   always_comb begin
      status_word = '0;
      status_word[`FC_BIT_BP_EN] = ctrl_q.backpressure_enable_bit;
      status_word[`FC_BIT_CUR_DUP] = half_duplex_active;
      status_word[`FC_BIT_CUR_RX] = pause_rx_enable;
      status_word[`FC_BIT_CUR_TX] = pause_tx_enable;
      status_word[`FC_BIT_RX_EN] = ctrl_q.manual_pause_receive_enable;
      status_word[`FC_BIT_TX_EN] = ctrl_q.manual_pause_transmit_enable;
      status_word[`FC_BIT_MANUAL] = ctrl_q.manual_flow_select;
   end

   // unmapped addresses and idle cycles return zero
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd && hit) begin
         reg_rdata <= {{`FC_RESERVED_W{1'b0}}, status_word};
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end
endmodule : port_flow_control_select
`default_nettype wire

// file: hdl/flow_ctrl_defs.svh
// Purpose: offsets, field positions and reset values of the port flow register
// Assumes: byte addressed register port, 32-bit data
// Notes: definitions only
`ifndef FLOW_CTRL_DEFS_SVH
`define FLOW_CTRL_DEFS_SVH
// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define FC_ADDR_W 12
`define FC_PORT2_OFFSET 12'h1a4
// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define FC_BIT_MANUAL 0
`define FC_BIT_TX_EN 1
`define FC_BIT_RX_EN 2
`define FC_BIT_CUR_TX 3
`define FC_BIT_CUR_RX 4
`define FC_BIT_CUR_DUP 5
`define FC_BIT_BP_EN 6
`define FC_FIELD_W 7
`define FC_RESERVED_W 25
`define FC_WRITABLE_MASK 7'h47
`define FC_CTRL_RESET 4'h0
`endif

// file: hdl/flow_ctrl_pkg.sv
// Purpose: types shared by the port flow control block
// Assumes: nothing
// Notes: constants live in flow_ctrl_defs.svh
package flow_ctrl_pkg;
   // ----------------------------------------------------------------------------
   // writable control fields
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic backpressure_enable_bit;
      logic manual_pause_receive_enable;
      logic manual_pause_transmit_enable;
      logic manual_flow_select;
   } ctrl_s;

   // in-force settings delivered to the mac
   typedef struct packed {
      logic half_duplex;
      logic pause_rx;
      logic pause_tx;
      logic backpressure;
   } effective_s;

   // default straps as loaded after reset release or by the loader
   typedef struct packed {
      logic backpressure_default_strap;
      logic full_duplex_pause_default_strap;
      logic manual_select_default_strap;
   } strap_s;

   // load sequencing after reset release
   typedef enum logic [2:0] {
      ST_RESET = 3'h1,
      ST_LOAD = 3'h2,
      ST_RUN = 3'h4
   } load_state_e;
endpackage : flow_ctrl_pkg

// file: hdl/sync2.sv
// Purpose: two flop synchroniser for a bus of levels
// Assumes: inputs are quasi static levels
// Notes: first stage is read only by the second stage
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------------------
   // two stage chain
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sync2
`default_nettype wire

// file: hdl/flow_resolve.sv
// Purpose: chooses the pause enables in force from manual bits or negotiation
// Assumes: negotiation inputs are already synchronised
// Notes: purely combinational
`timescale 1ns/10ps
`default_nettype none
module flow_resolve (
   input wire flow_ctrl_pkg::ctrl_s ctrl,
   input wire logic an_enable,
   input wire logic an_pause_rx,
   input wire logic an_pause_tx,
   input wire logic half_duplex,
   output flow_ctrl_pkg::effective_s eff
);
   logic use_manual;

   // ----------------------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------------------
   // manual bits govern when selected or when negotiation is off
   assign use_manual = ctrl.manual_flow_select | ~an_enable;

   // pause frames only exist in full duplex, so half duplex forces them off
   always_comb begin
      eff.half_duplex = half_duplex;
      eff.backpressure = ctrl.backpressure_enable_bit;
      if (half_duplex) begin
         eff.pause_rx = 1'b0;
         eff.pause_tx = 1'b0;
      end else if (use_manual) begin
         eff.pause_rx = ctrl.manual_pause_receive_enable;
         eff.pause_tx = ctrl.manual_pause_transmit_enable;
      end else begin
         eff.pause_rx = an_pause_rx;
         eff.pause_tx = an_pause_tx;
      end
   end
endmodule : flow_resolve
`default_nettype wire

// file: tb/flow_ctrl_sva.sv
// Purpose: port checks on the port two flow control register
// Assumes: run state from the fourth edge after reset release
// Notes: bound into the design at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "flow_ctrl_defs.svh"
module flow_ctrl_chk (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [`FC_ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic strap_reload,
   input wire flow_ctrl_pkg::strap_s strap_reload_values,
   input wire logic an_half_duplex,
   input wire logic pause_rx_enable,
   input wire logic pause_tx_enable,
   input wire logic backpressure_enable,
   input wire logic half_duplex_active
);
   // ------
   // helpers
   // ------
   logic [2:0] age_q;
   logic hit;
   // saturating edge count keeps start-up loading out of the checks
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         age_q <= 3'h0;
      end else if (age_q != 3'h7) begin
         age_q <= age_q + 3'h1;
      end
   end
   assign hit = reg_addr == `FC_PORT2_OFFSET;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_sw_write;
      reg_wr && hit && !strap_reload && age_q >= 3'h3;
   endsequence
   sequence s_dup_held;
      $stable(an_half_duplex) [*4];
   endsequence
   // ------
   // properties
   // ------
   a_write_sets_bp: assert property (s_sw_write |-> ##2
      backpressure_enable == $past(reg_wdata[6], 2)) else $error("bp write");
   a_reload_sets_bp: assert property (strap_reload && age_q >= 3'h3 |-> ##2
      backpressure_enable == $past(strap_reload_values[2], 2))
      else $error("bp reload");
   a_bp_needs_cause: assert property ($changed(backpressure_enable)
      && age_q >= 3'h5 |-> $past(reg_wr && hit || strap_reload, 2))
      else $error("bp moved alone");
   a_rdata_idle_zero: assert property (!reg_rd || !hit |=>
      reg_rdata == 32'h0) else $error("stray read data");
   a_reserved_zero: assert property (reg_rdata[31:7] == 25'h0)
      else $error("reserved bits set");
   a_read_status: assert property (reg_rd && hit |=> reg_rdata[6:3] ==
      {backpressure_enable, $past(half_duplex_active),
      $past(pause_rx_enable), $past(pause_tx_enable)}) else $error("status");
   a_half_no_pause: assert property (half_duplex_active |->
      !pause_rx_enable && !pause_tx_enable) else $error("pause in half");
   a_duplex_follows: assert property (s_dup_held ##0 age_q == 3'h7 |->
      half_duplex_active == an_half_duplex) else $error("duplex");
endmodule : flow_ctrl_chk
bind port_flow_control_select flow_ctrl_chk u_flow_ctrl_chk (
   .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .strap_reload(strap_reload), .strap_reload_values(strap_reload_values),
   .an_half_duplex(an_half_duplex), .pause_rx_enable(pause_rx_enable),
   .pause_tx_enable(pause_tx_enable),
   .backpressure_enable(backpressure_enable),
   .half_duplex_active(half_duplex_active));
`default_nettype wire

// file: tb/tb_port_flow_control_select.sv
// Purpose: self-checking bench for the port flow control register
// Assumes: negotiation inputs settle within five clocks
// Notes: read results are queued and checked by a monitor
`timescale 1ns/10ps
`default_nettype none
`include "flow_ctrl_defs.svh"
module tb_port_flow_control_select;
   logic clk_sys, rst, reg_wr, reg_rd, strap_reload, rd_seen;
   logic an_enable, an_pause_rx, an_pause_tx, an_half_duplex;
   logic pause_rx_enable, pause_tx_enable;
   logic backpressure_enable, half_duplex_active;
   logic [`FC_ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r;
   flow_ctrl_pkg::strap_s strap_pins, strap_reload_values;
   int num_errors, n_checks, seed, i;
   logic [31:0] exp_q[$];

   port_flow_control_select u_port_flow_control_select (
      .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .strap_pins(strap_pins),
      .strap_reload(strap_reload), .strap_reload_values(strap_reload_values),
      .an_enable(an_enable), .an_pause_rx(an_pause_rx),
      .an_pause_tx(an_pause_tx), .an_half_duplex(an_half_duplex),
      .pause_rx_enable(pause_rx_enable), .pause_tx_enable(pause_tx_enable),
      .backpressure_enable(backpressure_enable),
      .half_duplex_active(half_duplex_active));

   // 10 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // ------
   // tasks
   // ------
   task automatic report_and_stop;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: read %h not %h", $time, got, exp);
      end
   endtask : chk_rd
   task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: outputs %b not %b", $time, got, exp);
      end
   endtask : chk_out
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask : rd
   // fields are {bp, rx, tx, manual}; half duplex always kills pause
   function automatic logic [6:0] want(input logic [3:0] f);
      logic use_man;
      use_man = f[0] || !an_enable;
      return {f[3], an_half_duplex,
         !an_half_duplex && (use_man ? f[2] : an_pause_rx),
         !an_half_duplex && (use_man ? f[1] : an_pause_tx), f[2:0]};
   endfunction : want
   task automatic settle(input logic [3:0] f);
      logic [6:0] w;
      repeat (5) @(posedge clk_sys);
      w = want(f);
      chk_out({pause_rx_enable, pause_tx_enable, backpressure_enable,
         half_duplex_active}, {w[4], w[3], w[6], w[5]});
      rd(`FC_PORT2_OFFSET, {25'h0, w});
   endtask : settle
   // ------
   // read monitor and watchdog
   // ------
   // read data stands only in the cycle after the strobe edge
   always @(posedge clk_sys) begin
      if (rd_seen) begin
         chk_rd(reg_rdata, exp_q.pop_front());
      end
      rd_seen <= reg_rd;
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      num_errors++;
      report_and_stop;
   end
   // ------
   // main sequence
   // ------
   initial begin
      seed = 32'hb8107e2d;
      {num_errors, n_checks} = {32'h0, 32'h0};
      {rst, reg_wr, reg_rd, strap_reload, rd_seen} = 5'h10;
      reg_addr = 12'h0;
      reg_wdata = 32'h0;
      strap_pins = 3'h6;
      strap_reload_values = 3'h0;
      {an_enable, an_pause_rx, an_pause_tx, an_half_duplex} = 4'ha;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      settle(4'he);
      // all four mode pairs six times over, random data and status bits
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         r[0] = i[1];
         an_enable <= i[0];
         an_pause_rx <= r[9];
         an_pause_tx <= r[10];
         an_half_duplex <= r[11] & r[12];
         wr(`FC_PORT2_OFFSET, r);
         settle({r[6], r[2:0]});
      end
      wr(12'h1a8, 32'hffffffff);
      rd(12'h1a8, 32'h0);
      settle({r[6], r[2:0]});
      // loader reload beats a write in the same cycle
      @(posedge clk_sys);
      strap_reload <= 1'b1;
      strap_reload_values <= 3'h3;
      reg_wr <= 1'b1;
      reg_addr <= `FC_PORT2_OFFSET;
      reg_wdata <= 32'h40;
      @(posedge clk_sys);
      strap_reload <= 1'b0;
      reg_wr <= 1'b0;
      settle(4'h7);
      // let the monitor take the last read before the verdict
      repeat (2) @(posedge clk_sys);
      report_and_stop;
   end
endmodule : tb_port_flow_control_select
`default_nettype wire
